// [logic/aux_barcode_line_input.sv]
/*
 Auxiliary serial input: collects bar code strings from a terminal or
 handheld decoder and hands them to the host path after the reading pulse.
 Assumes read_pulse and err_status_en are asynchronous levels and the host
 path drains characters with a valid/ready handshake.
*/
module aux_barcode_line_input
   import aux_line_pkg::*;
#(
   parameter int unsigned DEPTH = QUEUE_DEPTH,
   parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Auxiliary serial line
   input wire logic aux_rxd,
   output logic aux_txd,
   // Reading control
   input wire logic read_pulse,
   input wire logic err_status_en,
   // Result stream to host path
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data,
   output logic out_last,
   output logic [3:0] out_status
);
   import aux_line_pkg::*;

   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < MAX_LEN + 1 || DEPTH != (1 << AW))
   begin : g_chk
      $error("Queue depth must be a power of two above the string limit");
   end

   aux_char_if chr ();

   aux_char_rx #(.BIT_CYC(BIT_CYC)) u_rx
   (
      .clk(clk),
      .rst(rst),
      .rxd(aux_rxd),
      .chr(chr)
   );

   logic [1:0] pulse_q, en_q;
   logic [8:0] mem [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_q;
   logic [AW:0] str_q;
   logic [5:0] len_q;
   logic sending_q;

   wire pulse_s = pulse_q[1];
   wire en_s = en_q[1];
   wire is_cr = chr.data == CHAR_CR;
   wire is_ctrl = chr.data < CHAR_SPACE || chr.data == CHAR_DEL;
   wire [AW:0] free = (AW + 1)'(DEPTH) - cnt_q;
   // Last slot kept for the terminator of the open string
   wire push_chr = chr.valid && !is_ctrl && len_q < 6'(MAX_LEN)
      && free > (AW + 1)'(1);
   wire push_end = chr.valid && is_cr && len_q != 6'h00
      && free != '0;
   wire push = push_chr || push_end;
   wire [8:0] head = mem[rp_q];
   wire pop = out_valid && out_ready;
   wire pop_end = pop && head[8];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pulse_q <= 2'b00;
         en_q <= 2'b00;
      end
      else
      begin
         pulse_q <= {pulse_q[0], read_pulse};
         en_q <= {en_q[0], err_status_en};
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wp_q] <= {push_end, chr.data};
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         str_q <= '0;
         len_q <= 6'h00;
         sending_q <= 1'b0;
      end
      else
      begin
         wp_q <= wp_q + AW'(push);
         rp_q <= rp_q + AW'(pop);
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
         str_q <= str_q + (AW + 1)'(push_end) - (AW + 1)'(pop_end);
         if (push_end)
            len_q <= 6'h00;
         else if (push_chr)
            len_q <= len_q + 6'h01;
         if (pop)
            sending_q <= !head[8];
      end
   end

   // Whole strings only; a string in flight is finished
   assign out_valid = str_q != '0 && (!pulse_s || sending_q);
   assign out_data = head[7:0];
   assign out_last = head[8];
   assign out_status = en_s ? AUX_DIAG_CODE : NO_DIAG_CODE;
   assign aux_txd = 1'b1;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_cr_closes;
      chr.valid && is_cr && len_q != 6'h00 && free != '0
         |=> len_q == 6'h00 && str_q != '0;
   endproperty
   a_cr_closes: assert property (p_cr_closes)
      else $error("CR did not close the string");

   property p_ctrl_dropped;
      chr.valid && is_ctrl && !is_cr |=> $stable(len_q) && $stable(wp_q);
   endproperty
   a_ctrl_dropped: assert property (p_ctrl_dropped)
      else $error("Control character was stored");

   property p_no_echo;
      aux_txd == 1'b1;
   endproperty
   a_no_echo: assert property (p_no_echo)
      else $error("Auxiliary line driven low");

   property p_after_pulse;
      out_valid && !sending_q |-> !pulse_s;
   endproperty
   a_after_pulse: assert property (p_after_pulse)
      else $error("String started during reading pulse");

   property p_max_len;
      len_q <= 6'(MAX_LEN);
   endproperty
   a_max_len: assert property (p_max_len)
      else $error("String longer than limit");

   property p_status;
      out_valid && out_last && en_s |-> out_status == AUX_DIAG_CODE;
   endproperty
   a_status: assert property (p_status)
      else $error("Auxiliary status code wrong");

   property p_format;
      out_valid && out_last |-> out_data == CHAR_CR;
   endproperty
   a_format: assert property (p_format)
      else $error("String end not marked by CR");

   property p_queue;
      pop_end |=> str_q == $past(str_q) - (AW + 1)'(1)
         + (AW + 1)'($past(push_end));
   endproperty
   a_queue: assert property (p_queue)
      else $error("Queued string count wrong");

   property p_clean_out;
      out_valid && !out_last |-> out_data >= CHAR_SPACE
         && out_data != CHAR_DEL;
   endproperty
   a_clean_out: assert property (p_clean_out)
      else $error("Control character forwarded");

   property p_empty_cr;
      chr.valid && is_cr && len_q == 6'h00 |=> $stable(wp_q);
   endproperty
   a_empty_cr: assert property (p_empty_cr)
      else $error("Empty string was stored");

   property p_overflow;
      chr.valid && !is_ctrl && len_q == 6'(MAX_LEN) |=> $stable(wp_q);
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("Character past the limit was stored");

   property p_in_flight;
      out_valid && sending_q && !out_ready
         |=> out_valid && $stable(out_data) && $stable(out_last);
   endproperty
   a_in_flight: assert property (p_in_flight)
      else $error("String in flight was cut");

   property p_no_overrun;
      cnt_q <= (AW + 1)'(DEPTH);
   endproperty
   a_no_overrun: assert property (p_no_overrun)
      else $error("Queue overrun");

   c_string_out: cover property (pop_end);
   c_two_queued: cover property (str_q == (AW + 1)'(2));
   c_held: cover property (str_q != '0 && pulse_s ##1 out_valid);
   c_overflow: cover property (chr.valid && !is_ctrl && len_q == 6'(MAX_LEN));
   c_cut_pulse: cover property (sending_q && pulse_s && pop);
endmodule : aux_barcode_line_input

// [logic/aux_line_pkg.sv]
/*
 Constants of the auxiliary serial input: line timing, character codes,
 string limits and the status tag given to auxiliary results.
 Assumes a single 20 MHz system clock.
*/
package aux_line_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned BAUD_RATE = 9_600;
   localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
   localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
   localparam int unsigned DATA_BITS = 8;
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_SPACE = 8'h20;
   localparam logic [7:0] CHAR_DEL = 8'h7F;
   localparam int unsigned MAX_LEN = 50;
   localparam logic [3:0] AUX_DIAG_CODE = 4'h7;
   localparam logic [3:0] NO_DIAG_CODE = 4'h0;
   localparam int unsigned QUEUE_DEPTH = 128;
   typedef enum logic [1:0]
   {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_t;
endpackage : aux_line_pkg

// [logic/aux_char_if.sv]
/*
 Carries one received character from the line receiver to the string
 collector. Assumes both ends share one clock.
*/
interface aux_char_if;
   logic valid;
   logic [7:0] data;
   modport src (output valid, output data);
   modport dst (input valid, input data);
endinterface : aux_char_if

// [logic/aux_char_rx.sv]
/*
 Asynchronous character receiver, 8 data bits, no parity, 1 stop bit.
 Assumes the line idles high and arrives unsynchronised.
*/
module aux_char_rx
   import aux_line_pkg::*;
#(
   parameter int unsigned BIT_CYC = BIT_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial line
   input wire logic rxd,
   // Received characters
   aux_char_if.src chr
);
   if (BIT_CYC < 4 || BIT_CYC > 4095)
   begin : g_chk
      $error("Bit period out of range");
   end

   logic [1:0] sync_q;
   logic [11:0] cnt_q, cnt_d;
   logic [2:0] bit_q, bit_d;
   logic [7:0] sh_q, sh_d;
   logic valid_q, valid_d;
   logic [7:0] data_q, data_d;
   rx_state_t st_q, st_d;
   wire line = sync_q[1];
   wire cnt_done = (cnt_q == 12'h000);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync_q <= 2'b11;
         st_q <= RX_IDLE;
         cnt_q <= 12'h000;
         bit_q <= 3'h0;
         sh_q <= 8'h00;
         valid_q <= 1'b0;
         data_q <= 8'h00;
      end
      else
      begin
         sync_q <= {sync_q[0], rxd};
         st_q <= st_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         sh_q <= sh_d;
         valid_q <= valid_d;
         data_q <= data_d;
      end
   end

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_done ? 12'h000 : cnt_q - 12'h001;
      bit_d = bit_q;
      sh_d = sh_q;
      valid_d = 1'b0;
      data_d = data_q;
      case (st_q)
         RX_IDLE:
         begin
            if (!line)
            begin
               st_d = RX_START;
               cnt_d = 12'(BIT_CYC / 2 - 1);
            end
         end
         RX_START:
         begin
            if (cnt_done)
            begin
               st_d = line ? RX_IDLE : RX_DATA;
               cnt_d = 12'(BIT_CYC - 1);
               bit_d = 3'h0;
            end
         end
         RX_DATA:
         begin
            if (cnt_done)
            begin
               sh_d = {line, sh_q[7:1]};
               cnt_d = 12'(BIT_CYC - 1);
               bit_d = bit_q + 3'h1;
               if (bit_q == 3'(DATA_BITS - 1))
                  st_d = RX_STOP;
            end
         end
         RX_STOP:
         begin
            if (cnt_done)
            begin
               st_d = RX_IDLE;
               // Framing error drops the character
               valid_d = line;
               data_d = line ? sh_q : data_q;
            end
         end
         default:
            st_d = RX_IDLE;
      endcase
   end

   assign chr.valid = valid_q;
   assign chr.data = data_q;
endmodule : aux_char_rx

// [bench/aux_term_model.sv]
/*
 Terminal model that sends characters on the auxiliary serial line.
 Assumes the bench clock; the line idles high between frames.
*/
module aux_term_model #(
   parameter int BIT_CYC = 16
)
(
   // Clock
   input wire logic clk,
   // Serial line
   output logic txd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial txd = 1'b1;
   // One 8N1 frame, LSB first, no framing bytes
   task automatic send(input logic [7:0] c);
      logic [9:0] f;
      f = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(negedge clk);
         txd = f[i];
         repeat (BIT_CYC - 1) @(negedge clk);
      end
   endtask : send
endmodule : aux_term_model

// [bench/tb.sv]
/*
 Testbench of the auxiliary bar code input: terminal model on the line,
 host stream drained here. Assumes a 20 MHz clock.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import aux_line_pkg::*;
   localparam int BC = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pulse = 1'b0;
   logic err_en = 1'b0;
   logic ready = 1'b0;
   logic rxd, txd, valid, last;
   logic [7:0] data;
   logic [3:0] status;
   int mismatches = 0;
   int n_tests = 0;
   int cycles = 0;

   always #25 clk = ~clk;

   aux_term_model #(.BIT_CYC(BC)) term (.clk(clk), .txd(rxd));

   aux_barcode_line_input #(.DEPTH(128), .BIT_CYC(BC)) dut (
      .clk(clk), .rst(rst), .aux_rxd(rxd), .aux_txd(txd),
      .read_pulse(pulse), .err_status_en(err_en), .out_valid(valid),
      .out_ready(ready), .out_data(data), .out_last(last),
      .out_status(status));

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         stop_test();
      end
   end

   task automatic cmp(input string what, input logic [7:0] exp, got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   // Wait for a character, check it, then take it
   task automatic take(input logic [7:0] c, input logic l,
      input logic [3:0] s);
      int n;
      n = 0;
      while (valid !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      cmp("out_valid", 8'h01, {7'h00, valid});
      cmp("out_data", c, data);
      cmp("out_last", {7'h00, l}, {7'h00, last});
      cmp("out_status", {4'h0, s}, {4'h0, status});
      cmp("aux_txd", 8'h01, {7'h00, txd});
      ready = 1'b1;
      @(negedge clk);
      ready = 1'b0;
      @(negedge clk);
   endtask : take

   task automatic t_pulse();
      pulse = 1'b1;
      err_en = 1'b1;
      term.send("1");
      term.send("2");
      term.send(CHAR_CR);
      repeat (20) @(negedge clk);
      cmp("out_valid", 8'h00, {7'h00, valid});
      pulse = 1'b0;
      take("1", 1'b0, AUX_DIAG_CODE);
      take("2", 1'b0, AUX_DIAG_CODE);
      take(CHAR_CR, 1'b1, AUX_DIAG_CODE);
      $display("test pulse done");
   endtask : t_pulse

   task automatic t_ctrl();
      logic [7:0] s [8] = '{"A", 8'h01, 8'h7F, "B", CHAR_CR, CHAR_CR,
         "C", CHAR_CR};
      pulse = 1'b1;
      err_en = 1'b0;
      foreach (s[i]) term.send(s[i]);
      pulse = 1'b0;
      take("A", 1'b0, NO_DIAG_CODE);
      take("B", 1'b0, NO_DIAG_CODE);
      take(CHAR_CR, 1'b1, NO_DIAG_CODE);
      take("C", 1'b0, NO_DIAG_CODE);
      take(CHAR_CR, 1'b1, NO_DIAG_CODE);
      cmp("out_valid", 8'h00, {7'h00, valid});
      $display("test ctrl done");
   endtask : t_ctrl

   task automatic t_long();
      pulse = 1'b1;
      for (int i = 0; i < 52; i++) term.send(8'h21 + i[7:0]);
      term.send(CHAR_CR);
      pulse = 1'b0;
      for (int i = 0; i < 50; i++)
         take(8'h21 + i[7:0], 1'b0, NO_DIAG_CODE);
      take(CHAR_CR, 1'b1, NO_DIAG_CODE);
      $display("test long done");
   endtask : t_long

   initial
   begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_pulse();
      t_ctrl();
      t_long();
      stop_test();
   end
endmodule : tb
